// ---- rtl/hlt_src_sel.sv ----
// Clock and external reset source selection with edge detection
`timescale 1ns/1ns
module hlt_src_sel (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [31:0] clkSources,
    input  wire logic [31:0] rstSources,
    input  wire logic [4:0]  clkSel,
    input  wire logic [4:0]  rstSel,
    input  wire logic        fallingEdge,
    output logic             srcTick,
    output logic             extLevel,
    output logic             extRise,
    output logic             extFall
);
    logic clkPrev_ff;
    logic extPrev_ff;
    logic clkNow;

    assign clkNow   = clkSources[clkSel];
    assign extLevel = rstSources[rstSel];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkPrev_ff <= 1'b0;
            extPrev_ff <= 1'b0;
        end else begin
            clkPrev_ff <= clkNow;
            extPrev_ff <= extLevel;
        end
    end

    // Chosen edge of the selected source advances the prescaler
    assign srcTick = fallingEdge ? (clkPrev_ff & ~clkNow)
                                 : (~clkPrev_ff & clkNow);
    assign extRise = ~extPrev_ff & extLevel;
    assign extFall = extPrev_ff & ~extLevel;
endmodule // hlt_src_sel

// ---- rtl/hlt_timer.sv ----
// 8-bit period timer with hardware limit control and AXI4-Lite registers
//
// How it works
// - Enable bit low holds the timer off with prescaler, postscaler and state reset.
// - Prescale field divides the input clock by two to its power.
// - Postscale field n divides period events by n plus one.
// - One-shot level modes clear the enable bit by hardware.
// - Prescaler sync bit aligns prescaler output to oscillator/4.
// - With prescaler sync set, the timer halts during Sleep.
// - Polarity bit picks falling (1) or rising (0) input edge.
// - Enable sync bit syncs the enable bit to input clock.
// - With enable sync, counting starts two input clocks later.
// - Counting follows the enable bit; stopping keeps the count.
// - After counter equals period, next timer clock clears it.
// - Five-bit mode field selects free, monostable, one-shot.
// - Clock source register low five bits select the clock.
// - Reset source register low five bits select external reset.
// - Eight-bit period register sets the wrap value.
// - Without prescaler sync, the timer keeps running in Sleep.
`timescale 1ns/1ns
`include "hlt_timer_cfg.svh"
module hlt_timer (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic [13:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [13:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] clkSources,
    input  wire logic [31:0] rstSources,
    input  wire logic        sleepMode,
    output logic             periodEvent,
    output logic             timerRunning
);
    hlt_timer_pkg::hlt_control_t control_ff;
    hlt_timer_pkg::hlt_limit_t   limit_ff;
    hlt_timer_pkg::hlt_state_t   state_ff, nxt_state;
    logic [4:0]  clkSel_ff, rstSel_ff;
    logic [7:0]  period_ff, counter_ff;
    logic [6:0]  preCnt_ff;
    logic [3:0]  postCnt_ff;
    logic [1:0]  onSync_ff, instrDiv_ff, bresp_ff, rresp_ff;
    logic        prePend_ff, bvalid_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic        periodEvent_ff, running_ff;
    logic        srcTick, extLevel, extRise, extFall, rdFire, rdKnown;
    logic        wrFire, wrLane, wrCounter, wrPeriod, wrControl, wrKnown;
    logic [11:0] wrIdx, rdIdx;
    logic [7:0]  rdByte;
    logic [6:0]  preMask;
    logic        onEff, sleepBlock, preActive, preOut, instrEn, timerTick;
    logic        edgeMode, levelMode, startEdge, extAtReset;
    logic        countTick, matchTick, scalerClear;
    hlt_src_sel u_src_sel (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .clkSources  (clkSources),
        .rstSources  (rstSources),
        .clkSel      (clkSel_ff),
        .rstSel      (rstSel_ff),
        .fallingEdge (limit_ff.clock_edge_polarity),
        .srcTick     (srcTick),
        .extLevel    (extLevel),
        .extRise     (extRise),
        .extFall     (extFall)
    );

    // Write address and data are taken together in one cycle
    assign wrFire = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
    assign s_axi_awready = wrFire;
    assign s_axi_wready  = wrFire;
    assign wrIdx  = s_axi_awaddr[13:2];
    assign wrLane = wrFire & s_axi_wstrb[0];
    assign wrKnown = (wrIdx >= `HLT_IDX_COUNTER)
                   && (wrIdx <= `HLT_IDX_RSTSEL);
    assign wrCounter = wrLane && (wrIdx == `HLT_IDX_COUNTER);
    assign wrPeriod  = wrLane && (wrIdx == `HLT_IDX_PERIOD);
    assign wrControl = wrLane && (wrIdx == `HLT_IDX_CONTROL);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `HLT_RESP_OKAY;
        end else if (wrFire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wrKnown ? `HLT_RESP_OKAY : `HLT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    assign s_axi_arready = ~rvalid_ff;
    assign rdFire = s_axi_arvalid & ~rvalid_ff;
    assign rdIdx  = s_axi_araddr[13:2];
    assign rdKnown = (rdIdx >= `HLT_IDX_COUNTER)
                   && (rdIdx <= `HLT_IDX_RSTSEL);

    always_comb begin
        rdByte = 8'h00;
        unique case (rdIdx)
            `HLT_IDX_COUNTER: rdByte = counter_ff;
            `HLT_IDX_PERIOD:  rdByte = period_ff;
            `HLT_IDX_CONTROL: rdByte = control_ff;
            `HLT_IDX_LIMIT:   rdByte = limit_ff;
            `HLT_IDX_CLKSEL:  rdByte = {3'h0, clkSel_ff};
            `HLT_IDX_RSTSEL:  rdByte = {3'h0, rstSel_ff};
            default:          rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `HLT_RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end else if (rdFire) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= rdKnown ? `HLT_RESP_OKAY : `HLT_RESP_SLVERR;
            rdata_ff  <= {24'h00_0000, rdByte};
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;

    // Configuration registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            limit_ff  <= `HLT_RST_LIMIT;
            clkSel_ff <= `HLT_RST_SEL;
            rstSel_ff <= `HLT_RST_SEL;
            period_ff <= `HLT_RST_PERIOD;
        end else if (wrLane) begin
            if (wrIdx == `HLT_IDX_LIMIT)
                limit_ff <= s_axi_wdata[7:0];
            if (wrIdx == `HLT_IDX_CLKSEL)
                clkSel_ff <= s_axi_wdata[4:0];
            if (wrIdx == `HLT_IDX_RSTSEL)
                rstSel_ff <= s_axi_wdata[4:0];
            if (wrPeriod)
                period_ff <= s_axi_wdata[7:0];
        end
    end

    // A software write wins over the hardware clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_ff <= `HLT_RST_CONTROL;
        end else if (wrControl) begin
            control_ff <= s_axi_wdata[7:0];
        end else if (levelMode && matchTick) begin
            control_ff.on <= 1'b0;
        end
    end

    // Mode decode
    assign edgeMode = (limit_ff.mode == `HLT_MODE_EDGE_R)
                   || (limit_ff.mode == `HLT_MODE_EDGE_F)
                   || (limit_ff.mode == `HLT_MODE_EDGE_RF);
    assign levelMode = (limit_ff.mode == `HLT_MODE_LVL_LO)
                    || (limit_ff.mode == `HLT_MODE_LVL_HI);
    always_comb begin
        startEdge = 1'b0;
        unique case (limit_ff.mode)
            `HLT_MODE_EDGE_R:  startEdge = extRise;
            `HLT_MODE_EDGE_F:  startEdge = extFall;
            `HLT_MODE_EDGE_RF: startEdge = extRise | extFall;
            default:           startEdge = 1'b0;
        endcase
    end
    assign extAtReset = levelMode
        && (extLevel == (limit_ff.mode == `HLT_MODE_LVL_HI));

    // Enable passes two selected-clock edges before taking effect
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            onSync_ff <= 2'b00;
        end else if (!control_ff.on) begin
            onSync_ff <= 2'b00;
        end else if (srcTick) begin
            onSync_ff <= {onSync_ff[0], 1'b1};
        end
    end
    assign onEff = limit_ff.enable_sync_enable ? onSync_ff[1]
                                               : control_ff.on;
    // Sleep stops the timer only when its output is tied to the core clock
    assign sleepBlock = limit_ff.prescaler_sync_enable & sleepMode;
    assign preActive  = onEff & ~sleepBlock;
    assign scalerClear = ~control_ff.on | wrCounter | wrPeriod;

    // Prescaler
    assign preMask = 7'((8'h01 << control_ff.prescale_select) - 8'h01);
    assign preOut  = preActive && srcTick
                  && ((preCnt_ff & preMask) == preMask);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            preCnt_ff <= 7'h00;
        end else if (scalerClear) begin
            preCnt_ff <= 7'h00;
        end else if (preActive && srcTick) begin
            preCnt_ff <= preCnt_ff + 7'h01;
        end
    end

    // Instruction clock enable and prescaler output alignment
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            instrDiv_ff <= 2'h0;
        end else begin
            instrDiv_ff <= instrDiv_ff + 2'h1;
        end
    end
    assign instrEn = (instrDiv_ff == `HLT_INSTR_DIV);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prePend_ff <= 1'b0;
        end else if (scalerClear || !limit_ff.prescaler_sync_enable) begin
            prePend_ff <= 1'b0;
        end else begin
            prePend_ff <= preOut | (prePend_ff & ~instrEn);
        end
    end
    assign timerTick = limit_ff.prescaler_sync_enable
                     ? (prePend_ff & instrEn & ~sleepBlock)
                     : preOut;

    // Start and stop control
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            hlt_timer_pkg::HLT_IDLE:
                if (onEff)
                    nxt_state = edgeMode ? hlt_timer_pkg::HLT_ARMED
                                         : hlt_timer_pkg::HLT_RUN;
            hlt_timer_pkg::HLT_ARMED:
                if (startEdge)
                    nxt_state = hlt_timer_pkg::HLT_RUN;
            hlt_timer_pkg::HLT_RUN:
                if (matchTick && edgeMode)
                    nxt_state = hlt_timer_pkg::HLT_ARMED;
                else if (matchTick && levelMode)
                    nxt_state = hlt_timer_pkg::HLT_IDLE;
        endcase
        if (!onEff)
            nxt_state = hlt_timer_pkg::HLT_IDLE;
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= hlt_timer_pkg::HLT_IDLE;
        end else if (!control_ff.on) begin
            state_ff <= hlt_timer_pkg::HLT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Counter
    assign countTick = timerTick && !extAtReset && control_ff.on
                    && (state_ff == hlt_timer_pkg::HLT_RUN);
    assign matchTick = countTick && (counter_ff == period_ff);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_ff <= `HLT_RST_COUNTER;
        end else if (wrCounter) begin
            counter_ff <= s_axi_wdata[7:0];
        end else if (extAtReset && control_ff.on) begin
            counter_ff <= 8'h00;
        end else if (matchTick) begin
            counter_ff <= 8'h00;
        end else if (countTick) begin
            counter_ff <= counter_ff + 8'h01;
        end
    end

    // Postscaler
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            postCnt_ff     <= 4'h0;
            periodEvent_ff <= 1'b0;
        end else if (scalerClear) begin
            postCnt_ff     <= 4'h0;
            periodEvent_ff <= 1'b0;
        end else begin
            periodEvent_ff <= 1'b0;
            if (matchTick) begin
                if (postCnt_ff == control_ff.postscale_select) begin
                    postCnt_ff     <= 4'h0;
                    periodEvent_ff <= 1'b1;
                end else begin
                    postCnt_ff <= postCnt_ff + 4'h1;
                end
            end
        end
    end
    assign periodEvent = periodEvent_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            running_ff <= 1'b0;
        end else begin
            running_ff <= (nxt_state == hlt_timer_pkg::HLT_RUN)
                          && control_ff.on;
        end
    end
    assign timerRunning = running_ff;

    off_clears_scalers_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !control_ff.on |=> (preCnt_ff == 7'h00) && (postCnt_ff == 4'h0)
                           && (state_ff == hlt_timer_pkg::HLT_IDLE))
        else $error("Timer off but scaler or state not reset");
    prescale_one_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (control_ff.prescale_select == 3'h0) && preActive && srcTick
            |-> preOut)
        else $error("Divide by one prescaler missed an input edge");
    postscale_event_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        matchTick && !scalerClear
            |=> periodEvent == ($past(postCnt_ff)
                == $past(control_ff.postscale_select)))
        else $error("Postscaler output does not match its setting");
    hw_clear_on_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        levelMode && matchTick && !wrControl |=> !control_ff.on)
        else $error("One-shot match did not clear enable");
    prescaler_sync_enable_aligned_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        limit_ff.prescaler_sync_enable && timerTick |-> instrEn)
        else $error("Synchronised tick off the instruction clock");
    sleep_halts_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        sleepBlock && !wrCounter |=> $stable(counter_ff))
        else $error("Counter moved in Sleep with prescaler sync");
    enable_sync_enable_delay_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        limit_ff.enable_sync_enable && $rose(control_ff.on)
            |-> !onEff ##1 !onEff)
        else $error("Synchronised enable took effect too early");
    period_wrap_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        matchTick && !wrCounter |=> counter_ff == 8'h00)
        else $error("Counter did not wrap after period match");
    stop_keeps_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !control_ff.on && !wrCounter |=> $stable(counter_ff))
        else $error("Counter changed while timer off");
    write_resets_a: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        wrPeriod || wrCounter |=> preCnt_ff == 7'h00)
        else $error("Prescaler not reset by counter or period write");
endmodule // hlt_timer

// ---- rtl/hlt_timer_cfg.svh ----
// Offsets, reset values, mode codes, timing counts and responses of the timer
`ifndef HLT_TIMER_CFG_SVH
`define HLT_TIMER_CFG_SVH
`define HLT_IDX_COUNTER   12'hFBA
`define HLT_IDX_PERIOD    12'hFBB
`define HLT_IDX_CONTROL   12'hFBC
`define HLT_IDX_LIMIT     12'hFBD
`define HLT_IDX_CLKSEL    12'hFBE
`define HLT_IDX_RSTSEL    12'hFBF
`define HLT_RST_COUNTER   8'h00
`define HLT_RST_PERIOD    8'hFF
`define HLT_RST_CONTROL   8'h00
`define HLT_RST_LIMIT     8'h00
`define HLT_RST_SEL       5'h00
`define HLT_MODE_EDGE_R   5'h11
`define HLT_MODE_EDGE_F   5'h12
`define HLT_MODE_EDGE_RF  5'h13
`define HLT_MODE_LVL_LO   5'h16
`define HLT_MODE_LVL_HI   5'h17
`define HLT_INSTR_DIV     2'h3
`define HLT_RESP_OKAY     2'h0
`define HLT_RESP_SLVERR   2'h2
`endif

// ---- rtl/hlt_timer_pkg.sv ----
// Types shared by the hardware limit timer files
package hlt_timer_pkg;
    typedef struct packed {
        logic       on;
        logic [2:0] prescale_select;
        logic [3:0] postscale_select;
    } hlt_control_t;

    typedef struct packed {
        logic       prescaler_sync_enable;
        logic       clock_edge_polarity;
        logic       enable_sync_enable;
        logic [4:0] mode;
    } hlt_limit_t;

    typedef enum logic [1:0] {
        HLT_IDLE,
        HLT_ARMED,
        HLT_RUN
    } hlt_state_t;
endpackage

// ---- tb/hlt_src_model.sv ----
// Model of the selected timer clock source and external reset lines
`timescale 1ns/1ns
module hlt_src_model (
    input  wire logic       sys_clk,
    input  wire logic [4:0] clkIdx,
    input  wire logic [4:0] rstIdx,
    input  wire logic       rstLvl,
    output logic     [31:0] clkSources,
    output logic     [31:0] rstSources
);
    logic srcLvl;

    initial srcLvl = 1'b0;

    // Unselected clocks stand still, unselected resets show the other level
    assign clkSources = {31'h0, srcLvl} << clkIdx;
    assign rstSources = ({32{~rstLvl}} & ~(32'h1 << rstIdx))
                      | ({31'h0, rstLvl} << rstIdx);

    // Each level lasts three system clocks so every edge is seen
    task automatic hold(input logic lvl);
        srcLvl <= lvl;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            hold(1'b1);
            hold(1'b0);
        end
    endtask
endmodule // hlt_src_model

// ---- tb/hw_limit_8bit_timer_ctrl_test.sv ----
// Register-level bench of the hardware limit timer
`timescale 1ns/1ns
`include "hlt_timer_cfg.svh"
module hw_limit_8bit_timer_ctrl_test;
    logic        sys_clk;
    logic        reset_n;
    logic [13:0] s_axi_awaddr;
    logic [13:0] s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid;
    logic        s_axi_wvalid;
    logic        s_axi_bready;
    logic        s_axi_arvalid;
    logic        s_axi_rready;
    logic        sleepMode;
    logic        rstLvl;
    logic [4:0]  clkIdx;
    logic [4:0]  rstIdx;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, periodEvent, timerRunning;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, clkSources, rstSources;
    int          miscompares;
    int          numChecks;
    int          evCnt;
    int          edges;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (periodEvent === 1'b1) evCnt++;

    hlt_timer dut (
        .sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .clkSources, .rstSources,
        .sleepMode, .periodEvent, .timerRunning
    );

    hlt_src_model src (
        .sys_clk, .clkIdx, .rstIdx, .rstLvl, .clkSources, .rstSources
    );

    task automatic summarize;
        if (miscompares == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stall(inout int n);
        @(posedge sys_clk);
        n++;
        if (n > 40) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                      input logic [1:0] er = `HLT_RESP_OKAY);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do stall(n); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do stall(n); while (s_axi_bvalid !== 1'b1);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] idx, input logic [7:0] x,
                      input logic [1:0] er = `HLT_RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do stall(n); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do stall(n); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, {24'h0, x});
        check({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Timer is stopped before any setup change, polarity included
    task automatic start(input logic [7:0] ctl, lim, per);
        wr(`HLT_IDX_CONTROL, 8'h00);
        wr(`HLT_IDX_LIMIT, lim);
        wr(`HLT_IDX_PERIOD, per);
        wr(`HLT_IDX_COUNTER, 8'h00);
        evCnt = 0;
        wr(`HLT_IDX_CONTROL, {1'b1, ctl[6:0]});
    endtask

    initial begin
        sys_clk = 1'b0;
        miscompares = 0;
        numChecks = 0;
        evCnt = 0;
        reset_n <= 1'b0;
        s_axi_awaddr <= 14'h0000;
        s_axi_araddr <= 14'h0000;
        s_axi_wdata <= 32'h0000_0000;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        sleepMode <= 1'b0;
        rstLvl <= 1'b0;
        clkIdx <= 5'h00;
        rstIdx <= 5'h00;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(`HLT_IDX_COUNTER, 8'h00);
        rd(`HLT_IDX_PERIOD, 8'hFF);
        rd(`HLT_IDX_CONTROL, 8'h00);
        rd(`HLT_IDX_LIMIT, 8'h00);
        rd(`HLT_IDX_CLKSEL, 8'h00);
        rd(`HLT_IDX_RSTSEL, 8'h00);
        rd(12'hFB9, 8'h00, `HLT_RESP_SLVERR);
        wr(12'hFC0, 8'h55, `HLT_RESP_SLVERR);
        // Low byte lane off: the write is answered but not stored
        s_axi_wstrb <= 4'hE;
        wr(`HLT_IDX_PERIOD, 8'h12);
        s_axi_wstrb <= 4'hF;
        rd(`HLT_IDX_PERIOD, 8'hFF);
        wr(`HLT_IDX_CLKSEL, 8'hE7);
        rd(`HLT_IDX_CLKSEL, 8'h07);
        wr(`HLT_IDX_RSTSEL, 8'hE9);
        rd(`HLT_IDX_RSTSEL, 8'h09);
        clkIdx <= 5'h07;
        rstIdx <= 5'h09;
        // Every prescale and postscale code, one edge short then exact
        for (int i = 0; i < 16; i++) begin
            edges = (1 << (i % 8)) * (i + 1);
            start({1'b0, 3'(i % 8), 4'(i)}, 8'h00, 8'h00);
            src.pulses(edges - 1);
            check(evCnt, 0);
            src.pulses(1);
            check(evCnt, 1);
        end
        start(8'h00, 8'h00, 8'h05);
        src.pulses(9);
        rd(`HLT_IDX_COUNTER, 8'h03);
        check(evCnt, 1);
        check({31'h0, timerRunning}, 32'h1);
        wr(`HLT_IDX_CONTROL, 8'h00);
        src.pulses(3);
        rd(`HLT_IDX_COUNTER, 8'h03);
        check({31'h0, timerRunning}, 32'h0);
        start(8'h20, 8'h00, 8'hFF);
        src.pulses(3);
        wr(`HLT_IDX_COUNTER, 8'h00);
        src.pulses(3);
        rd(`HLT_IDX_COUNTER, 8'h00);
        src.pulses(1);
        rd(`HLT_IDX_COUNTER, 8'h01);
        for (int p = 0; p < 2; p++) begin
            start(8'h00, {1'b0, 1'(p), 6'h00}, 8'hFF);
            src.hold(1'b1);
            rd(`HLT_IDX_COUNTER, {7'h0, 1'(p == 0)});
            src.hold(1'b0);
            rd(`HLT_IDX_COUNTER, 8'h01);
        end
        start(8'h00, 8'h20, 8'hFF);
        src.pulses(5);
        rd(`HLT_IDX_COUNTER, 8'h03);
        sleepMode <= 1'b1;
        start(8'h00, 8'h80, 8'hFF);
        src.pulses(4);
        rd(`HLT_IDX_COUNTER, 8'h00);
        sleepMode <= 1'b0;
        src.pulses(4);
        rd(`HLT_IDX_COUNTER, 8'h04);
        sleepMode <= 1'b1;
        start(8'h00, 8'h00, 8'hFF);
        src.pulses(4);
        rd(`HLT_IDX_COUNTER, 8'h04);
        sleepMode <= 1'b0;
        clkIdx <= 5'h03;
        start(8'h00, 8'h00, 8'hFF);
        src.pulses(4);
        rd(`HLT_IDX_COUNTER, 8'h00);
        clkIdx <= 5'h07;
        rstLvl <= 1'b1;
        start(8'h00, 8'h17, 8'h02);
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h00);
        rstLvl <= 1'b0;
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h02);
        src.pulses(1);
        rd(`HLT_IDX_COUNTER, 8'h00);
        rd(`HLT_IDX_CONTROL, 8'h00);
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h00);
        start(8'h00, 8'h11, 8'hFF);
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h00);
        rstLvl <= 1'b1;
        repeat (3) @(posedge sys_clk);
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h02);
        start(8'h00, 8'h12, 8'hFF);
        src.pulses(1);
        rd(`HLT_IDX_COUNTER, 8'h00);
        rstLvl <= 1'b0;
        repeat (3) @(posedge sys_clk);
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h02);
        start(8'h00, 8'h16, 8'hFF);
        src.pulses(1);
        rd(`HLT_IDX_COUNTER, 8'h00);
        rstLvl <= 1'b1;
        src.pulses(2);
        rd(`HLT_IDX_COUNTER, 8'h02);
        summarize();
    end
endmodule // hw_limit_8bit_timer_ctrl_test
